/* hw/bgw_top.sv */
// boot guard: selection watchdog and progress watchdog with reset actions
`timescale 1ns/1ps
`default_nettype none
`include "bgw_cfg.svh"
module bgw_top import bgw_pkg::*; #(
	parameter int unsigned TICK_CYCLES = `BGW_TICK_CYCLES,
	parameter int unsigned SEL_TICKS   = `BGW_SEL_TICKS,
	parameter int unsigned PROG_TICKS  = `BGW_PROG_TICKS,
	parameter int unsigned NPROC       = `BGW_NPROC,
	parameter int unsigned IDW         = $clog2(NPROC)
) (
	// clock and hard reset
	input  wire logic             core_clk_i,
	input  wire logic             reset_i,
	// firmware controls, one-cycle pulses
	input  wire logic             sel_disable_i,
	input  wire logic             prog_enable_i,
	input  wire logic             prog_disable_i,
	input  wire logic             fail_ack_i,
	// identity of the processor currently acting as boot processor
	input  wire logic [IDW-1:0]   boot_proc_id_i,
	// reset actions, one-cycle pulses
	output logic                  sys_reset_o,
	output logic                  async_reset_o,
	// processor disable mask, sticky until hard reset
	output logic [NPROC-1:0]      proc_disable_o,
	// status for firmware
	output logic                  sel_running_o,
	output logic                  prog_running_o,
	output logic                  sel_fail_o,
	output logic                  prog_fail_o
);

	localparam int unsigned PW  = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
	localparam int unsigned SCW = $clog2(SEL_TICKS + 1);
	localparam int unsigned PCW = $clog2(PROG_TICKS + 1);

	if (TICK_CYCLES < 2 || SEL_TICKS < 1 || PROG_TICKS < 1 || NPROC < 2) begin : g_chk
		$error("bgw_top: parameter values out of range");
	end

	logic [PW-1:0]  pre_r;
	logic           tick_r;
	logic           sel_start_r;
	logic           sel_run_w;
	logic           sel_exp_w;
	logic [SCW-1:0] sel_cnt_w;
	logic           prog_run_w;
	logic           prog_exp_w;
	logic [PCW-1:0] prog_cnt_w;

	// free-running time base, one tick per period
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pre_r  <= '0;
			tick_r <= 1'b0;
		end else begin
			if (pre_r == PW'(TICK_CYCLES - 1)) begin
				pre_r  <= '0;
				tick_r <= 1'b1;
			end else begin
				pre_r  <= pre_r + 1'b1;
				tick_r <= 1'b0;
			end
		end
	end

	// selection guard re-arms whenever the system leaves a reset
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			sel_start_r <= 1'b1;
		end else begin
			sel_start_r <= sel_exp_w || prog_exp_w;
		end
	end

	// two separate timer instances share the time base; a progress expiry also re-arms the selection timer
	bgw_timer #(
		.LIMIT     (SEL_TICKS),
		.CW        (SCW)
	) u_sel (
		.core_clk_i(core_clk_i),
		.reset_i   (reset_i),
		.tick_i    (tick_r),
		.start_i   (sel_start_r),
		.stop_i    (sel_disable_i),
		.running_o (sel_run_w),
		.expire_o  (sel_exp_w),
		.count_o   (sel_cnt_w)
	);

	bgw_timer #(
		.LIMIT     (PROG_TICKS),
		.CW        (PCW)
	) u_prog (
		.core_clk_i(core_clk_i),
		.reset_i   (reset_i),
		.tick_i    (tick_r),
		.start_i   (prog_enable_i),
		.stop_i    (prog_disable_i || prog_exp_w),
		.running_o (prog_run_w),
		.expire_o  (prog_exp_w),
		.count_o   (prog_cnt_w)
	);

	// reset pulses; expire is a single-cycle state, so each fires once
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			sys_reset_o   <= 1'b0;
			async_reset_o <= 1'b0;
		end else begin
			sys_reset_o   <= sel_exp_w;
			async_reset_o <= prog_exp_w;
		end
	end

	// only the selection expiry marks the boot processor as failed
	for (genvar i = 0; i < NPROC; i++) begin : g_proc
		always_ff @(posedge core_clk_i or posedge reset_i) begin
			if (reset_i) begin
				proc_disable_o[i] <= 1'b0;
			end else if (sel_exp_w && boot_proc_id_i == IDW'(i)) begin
				proc_disable_o[i] <= 1'b1;
			end
		end
	end

	// failure flags for reporting on the next boot; set wins over ack
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			sel_fail_o  <= 1'b0;
			prog_fail_o <= 1'b0;
		end else begin
			sel_fail_o  <= sel_exp_w || (sel_fail_o && !fail_ack_i);
			prog_fail_o <= prog_exp_w || (prog_fail_o && !fail_ack_i);
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			sel_running_o  <= 1'b0;
			prog_running_o <= 1'b0;
		end else begin
			sel_running_o  <= sel_run_w;
			prog_running_o <= prog_run_w;
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	property p_sel_autostart;
		sel_start_r && !sel_disable_i |=> sel_run_w ##1 sel_running_o;
	endproperty
	a_sel_autostart: assert property (p_sel_autostart)
		else $error("selection watchdog did not start by itself");

	property p_sel_limit;
		sel_exp_w |-> sel_cnt_w == SCW'(SEL_TICKS) && $past(tick_r);
	endproperty
	a_sel_limit: assert property (p_sel_limit)
		else $error("selection watchdog expired at the wrong count");

	property p_prog_limit;
		prog_exp_w |-> prog_cnt_w == PCW'(PROG_TICKS) && $past(tick_r);
	endproperty
	a_prog_limit: assert property (p_prog_limit)
		else $error("progress watchdog expired at the wrong count");

	property p_sel_action;
		sel_exp_w |=> sys_reset_o && proc_disable_o[$past(boot_proc_id_i)];
	endproperty
	a_sel_action: assert property (p_sel_action)
		else $error("selection expiry did not reset and disable processor");

	property p_prog_action;
		prog_exp_w |=> async_reset_o && proc_disable_o == $past(proc_disable_o);
	endproperty
	a_prog_action: assert property (p_prog_action)
		else $error("progress expiry wrong reset action");

	property p_independent;
		prog_exp_w && !sel_exp_w |=> !sys_reset_o;
	endproperty
	a_independent: assert property (p_independent)
		else $error("progress expiry caused a selection reset");

	property p_cancel;
		sel_run_w && sel_disable_i |=> !sel_exp_w ##1 !sys_reset_o;
	endproperty
	a_cancel: assert property (p_cancel)
		else $error("disabled selection watchdog still fired");

	property p_once;
		async_reset_o |=> !async_reset_o [*2];
	endproperty
	a_once: assert property (p_once)
		else $error("progress reset pulse repeated");

	property p_sel_once;
		sys_reset_o |=> !sys_reset_o [*2];
	endproperty
	a_sel_once: assert property (p_sel_once)
		else $error("selection reset pulse repeated");

	property p_prog_cancel;
		prog_run_w && prog_disable_i |=> !prog_exp_w ##1 !async_reset_o;
	endproperty
	a_prog_cancel: assert property (p_prog_cancel)
		else $error("disabled progress watchdog still fired");

	property p_mask_sticky;
		!sel_exp_w |=> proc_disable_o == $past(proc_disable_o);
	endproperty
	a_mask_sticky: assert property (p_mask_sticky)
		else $error("processor mask changed without selection expiry");

endmodule
`default_nettype wire

/* hw/bgw_cfg.svh */
// timing constants for the boot guard watchdog pair
`ifndef BGW_CFG_SVH
`define BGW_CFG_SVH

`define BGW_CLK_PERIOD_NS    10
`define BGW_TICK_PERIOD_US   1000
`define BGW_TICK_CYCLES      ((`BGW_TICK_PERIOD_US * 1000) / `BGW_CLK_PERIOD_NS)
`define BGW_SEL_TIMEOUT_S    10
`define BGW_SEL_TICKS        ((`BGW_SEL_TIMEOUT_S * 1000000) / `BGW_TICK_PERIOD_US)
`define BGW_PROG_TIMEOUT_MIN 12
`define BGW_PROG_TICKS       ((`BGW_PROG_TIMEOUT_MIN * 60 * 1000000) / `BGW_TICK_PERIOD_US)
`define BGW_NPROC            8

`endif

/* hw/bgw_pkg.sv */
// types shared by the boot guard watchdog modules
`default_nettype none
package bgw_pkg;
	typedef enum logic [2:0] {
		BGW_IDLE = 3'h1,
		BGW_RUN  = 3'h2,
		BGW_FIRE = 3'h4
	} bgw_tmr_state_t;
endpackage
`default_nettype wire

/* hw/bgw_timer.sv */
// one watchdog: counts time base ticks from start, fires once at the limit
`timescale 1ns/1ps
`default_nettype none
module bgw_timer import bgw_pkg::*; #(
	parameter int unsigned LIMIT = 10,
	parameter int unsigned CW    = $clog2(LIMIT + 1)
) (
	// clock and reset
	input  wire logic          core_clk_i,
	input  wire logic          reset_i,
	// control
	input  wire logic          tick_i,
	input  wire logic          start_i,
	input  wire logic          stop_i,
	// status
	output logic               running_o,
	output logic               expire_o,
	output logic [CW-1:0]      count_o
);

	if (LIMIT < 1 || CW < $clog2(LIMIT + 1)) begin : g_chk
		$error("bgw_timer: LIMIT below one or CW too narrow for it");
	end

	bgw_tmr_state_t state_r;
	logic [CW-1:0]  cnt_r;

	// stop outranks the final tick, so a late disable still cancels expiry
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_r <= BGW_IDLE;
			cnt_r   <= '0;
		end else begin
			case (state_r)
				BGW_IDLE: begin
					if (start_i && !stop_i) begin
						state_r <= BGW_RUN;
						cnt_r   <= '0;
					end
				end
				BGW_RUN: begin
					if (stop_i) begin
						state_r <= BGW_IDLE;
					end else if (start_i) begin
						cnt_r <= '0;
					end else if (tick_i) begin
						cnt_r <= cnt_r + 1'b1;
						if (cnt_r == CW'(LIMIT - 1)) begin
							state_r <= BGW_FIRE;
						end
					end
				end
				BGW_FIRE: begin
					state_r <= BGW_IDLE;
				end
				default: begin
					state_r <= BGW_IDLE;
				end
			endcase
		end
	end

	assign running_o = (state_r == BGW_RUN);
	assign expire_o  = (state_r == BGW_FIRE);
	assign count_o   = cnt_r;

endmodule
`default_nettype wire

/* testbench/bgw_fw_model.sv */
// boot firmware model driving the watchdog control pulses
`timescale 1ns/1ps
`default_nettype none
module bgw_fw_model (
	// clock and sequencing
	input  wire logic       core_clk_i,
	input  wire logic       go_i,
	input  wire logic [1:0] mode_i,
	input  wire logic       ack_en_i,
	input  wire logic       fail_i,
	// control pulses
	output logic            sel_disable_o,
	output logic            prog_enable_o,
	output logic            prog_disable_o,
	output logic            fail_ack_o
);
	int step = 0;
	// mode 0 hangs, 1 stalls in self-test, 2 boots cleanly
	always @(negedge core_clk_i) begin
		step = go_i ? step + 1 : 0;
		prog_enable_o  <= go_i && mode_i != 2'h0 && step == 1;
		sel_disable_o  <= go_i && mode_i != 2'h0 && step == 2;
		prog_disable_o <= go_i && mode_i == 2'h2 && step == 10;
		fail_ack_o     <= ack_en_i && fail_i && !fail_ack_o;
	end
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// self-checking bench for the boot guard watchdog pair
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int TC = 4;
	localparam int ST = 3;
	localparam int PT = 5;
	typedef struct {logic [2:0] id; logic [1:0] mode; logic sys; logic asy; logic [7:0] mask;} bgw_row_t;
	logic       core_clk_i = 1'h0;
	logic       reset_i    = 1'h1;
	logic       go         = 1'h0;
	logic       ack_en     = 1'h0;
	logic [2:0] id         = 3'h0;
	logic [1:0] mode       = 2'h0;
	logic       sel_dis, prog_en, prog_dis, ack, sys_rst, async_rst;
	logic       sel_run, prog_run, sel_fail, prog_fail;
	logic [7:0] mask;
	int         fails = 0;
	int         n_tests = 0;
	int         t;
	bgw_row_t   rows [5] = '{
		'{3'h5, 2'h0, 1'h1, 1'h0, 8'h20},
		'{3'h0, 2'h0, 1'h1, 1'h0, 8'h01},
		'{3'h7, 2'h0, 1'h1, 1'h0, 8'h80},
		'{3'h2, 2'h1, 1'h0, 1'h1, 8'h00},
		'{3'h3, 2'h2, 1'h0, 1'h0, 8'h00}};

	always #5 core_clk_i = ~core_clk_i;

	bgw_top #(.TICK_CYCLES(TC), .SEL_TICKS(ST), .PROG_TICKS(PT), .NPROC(8)) u_bgw_top (
		.core_clk_i(core_clk_i), .reset_i(reset_i), .sel_disable_i(sel_dis),
		.prog_enable_i(prog_en), .prog_disable_i(prog_dis), .fail_ack_i(ack),
		.boot_proc_id_i(id), .sys_reset_o(sys_rst), .async_reset_o(async_rst),
		.proc_disable_o(mask), .sel_running_o(sel_run), .prog_running_o(prog_run),
		.sel_fail_o(sel_fail), .prog_fail_o(prog_fail));

	bgw_fw_model u_bgw_fw_model (
		.core_clk_i(core_clk_i), .go_i(go), .mode_i(mode), .ack_en_i(ack_en),
		.fail_i(sel_fail | prog_fail), .sel_disable_o(sel_dis), .prog_enable_o(prog_en),
		.prog_disable_o(prog_dis), .fail_ack_o(ack));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("tests=%0d fails=%0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic do_reset();
		@(negedge core_clk_i);
		reset_i = 1'h1;
		go <= 1'h0;
		repeat (10) @(negedge core_clk_i);
		check({sys_rst, async_rst, mask, sel_run, prog_run}, 32'h0);
		reset_i = 1'h0;
		go <= 1'h1;
	endtask

	// bounded wait for a reset action; running out is a fault only when one is due
	task automatic watch(input int lim, input logic must);
		t = 0;
		while (t < lim && !(sys_rst === 1'h1 || async_rst === 1'h1)) begin
			@(negedge core_clk_i);
			t++;
		end
		if (must && t >= lim) begin
			check(t, lim - 1);
			summarize();
		end
	endtask

	initial begin
		#100000;
		fails++;
		summarize();
	end

	initial begin
		foreach (rows[i]) begin
			id = rows[i].id;
			mode = rows[i].mode;
			do_reset();
			watch(40, rows[i].sys | rows[i].asy);
			check(sys_rst, rows[i].sys);
			check(async_rst, rows[i].asy);
			check(mask, rows[i].mask);
			if (t < 40) check(rows[i].asy ? (t >= (PT-1)*TC && t <= PT*TC+4)
				: (t >= (ST-1)*TC && t <= ST*TC+4), 1);
			@(negedge core_clk_i);
			check({sys_rst, async_rst, sel_fail, prog_fail},
				{2'h0, rows[i].sys, rows[i].asy});
			$display("row %0d done", i);
		end
		// mask is sticky across a second expiry with another processor
		id = 3'h5;
		mode = 2'h0;
		do_reset();
		repeat (3) @(negedge core_clk_i);
		check(sel_run, 1);
		watch(40, 1'h1);
		@(negedge core_clk_i);
		id = 3'h3;
		watch(40, 1'h1);
		check(sys_rst, 1);
		check(mask, 8'h28);
		@(negedge core_clk_i);
		ack_en <= 1'h1;
		repeat (3) @(negedge core_clk_i);
		check(sel_fail, 0);
		ack_en <= 1'h0;
		$display("sticky mask test done");
		// progress guard running, selection guard stopped by firmware
		mode = 2'h1;
		do_reset();
		repeat (3) @(negedge core_clk_i);
		check(prog_run, 1);
		@(negedge core_clk_i);
		check(sel_run, 0);
		$display("running flags test done");
		summarize();
	end
endmodule
`default_nettype wire
